// File: rtl/csof_pkg.sv
// Package of offsets, field positions and reset values for the block
package csof_pkg;

  // ****************************************************************
  // Register access geometry
  // ****************************************************************
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_THR_CFG   = 10'h01a;
  localparam logic [ADDR_W-1:0] OFS_STATUS_RB = 10'h01f;
  localparam logic [ADDR_W-1:0] OFS_OUTPUT_ZERO_CTRL = 10'h0f0;

  // ****************************************************************
  // Threshold configuration fields
  // ****************************************************************
  localparam int unsigned THR_SEL_BIT = 6;
  localparam logic        THR_SEL_RST = 1'h0;

  // ****************************************************************
  // Status readback fields
  // ****************************************************************
  localparam int unsigned ST_W          = 6;
  localparam int unsigned ST_LOCK_BIT   = 0;
  localparam int unsigned ST_PRI_BIT    = 1;
  localparam int unsigned ST_SEC_BIT    = 2;
  localparam int unsigned ST_OSC_BIT    = 3;
  localparam int unsigned ST_SECSEL_BIT = 4;
  localparam int unsigned ST_HOLD_BIT   = 5;

  // ****************************************************************
  // Output zero driver control fields
  // ****************************************************************
  localparam int unsigned CTL_FMT_BIT   = 7;
  localparam int unsigned CTL_LEG_HI    = 6;
  localparam int unsigned CTL_LEG_LO    = 5;
  localparam int unsigned CTL_POL_HI    = 4;
  localparam int unsigned CTL_POL_LO    = 3;
  localparam logic [7:0]  CTL_WR_MASK   = 8'hf8;
  localparam logic [7:0]  CTL_RST       = 8'h60;

  // ****************************************************************
  // Leg configuration codes
  // ****************************************************************
  localparam logic [1:0]  LEG_NONE      = 2'h0;
  localparam logic [1:0]  LEG_A_ONLY    = 2'h1;
  localparam logic [1:0]  LEG_B_ONLY    = 2'h2;
  localparam logic [1:0]  LEG_BOTH      = 2'h3;

  // ****************************************************************
  // Miscellaneous
  // ****************************************************************
  localparam logic [7:0]  RD_UNMAPPED   = 8'h00;
  localparam int unsigned SYNC_STAGES   = 2;

endpackage

// File: rtl/csof_sync.sv
// Two-stage synchroniser bank for asynchronous status levels
`timescale 1ns/1ps
module csof_sync #(
  parameter int unsigned W = 6
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  // ****************************************************************
  // One two-flop chain per bit
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < W; gi = gi + 1)
    begin : g_bit
      logic meta_r;
      logic stable_r;

      always_ff @(posedge clk_sys_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          meta_r   <= 1'b0;
          stable_r <= 1'b0;
        end
        else
        begin
          meta_r   <= async_i[gi];
          stable_r <= meta_r;
        end
      end

      assign sync_o[gi] = stable_r;
    end
  endgenerate

endmodule

// File: rtl/csof_regs.sv
// Status readback and output zero driver control register logic
//
// How it works
// - Bit 5 shows live holdover state
// - Bit 4 set when secondary reference selected
// - Bit 3 set when oscillator above threshold
// - Bit 2 set when secondary reference above threshold
// - Bit 1 set when primary reference above threshold
// - Bit 0 shows PLL digital lock
// - Control bit 7 picks LVDS or CMOS
// - Leg field enables legs A and B in CMOS format only; in LVDS both legs stay enabled
// - Polarity field combined with format bit
`timescale 1ns/1ps
module csof_regs #(
  parameter int unsigned ADDR_W = csof_pkg::ADDR_W
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_b_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  output logic                   reg_rvalid_o,
  input  wire logic              holdover_active_i,
  input  wire logic              secondary_reference_sel_i,
  input  wire logic              osc_above_thr_i,
  input  wire logic              secondary_reference_above_thr_i,
  input  wire logic              primary_reference_above_thr_i,
  input  wire logic              pll_locked_i,
  output logic                   freq_thr_sel_o,
  output logic                   output_zero_cmos_o,
  output logic                   output_zero_leg_a_en_o,
  output logic                   output_zero_leg_b_en_o,
  output logic                   output_zero_leg_a_inv_o,
  output logic                   output_zero_leg_b_inv_o
);

  // ****************************************************************
  // Status synchronisation
  // ****************************************************************
  logic [csof_pkg::ST_W-1:0] status_async;
  logic [csof_pkg::ST_W-1:0] status_sync;

  always_comb
  begin
    status_async = '0;
    status_async[csof_pkg::ST_HOLD_BIT]   = holdover_active_i;
    status_async[csof_pkg::ST_SECSEL_BIT] = secondary_reference_sel_i;
    status_async[csof_pkg::ST_OSC_BIT]    = osc_above_thr_i;
    status_async[csof_pkg::ST_SEC_BIT]    =
      secondary_reference_above_thr_i;
    status_async[csof_pkg::ST_PRI_BIT]    =
      primary_reference_above_thr_i;
    status_async[csof_pkg::ST_LOCK_BIT]   = pll_locked_i;
  end

  csof_sync #(
    .W         (csof_pkg::ST_W)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   (status_async),
    .sync_o    (status_sync)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic hit_thr;
  logic hit_status;
  logic hit_ctrl;

  assign hit_thr    = (reg_addr_i == csof_pkg::OFS_THR_CFG);
  assign hit_status = (reg_addr_i == csof_pkg::OFS_STATUS_RB);
  assign hit_ctrl   = (reg_addr_i == csof_pkg::OFS_OUTPUT_ZERO_CTRL);

  // ****************************************************************
  // Threshold select configuration
  // ****************************************************************
  logic thr_sel_r;

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      thr_sel_r <= csof_pkg::THR_SEL_RST;
    else if (reg_wr_i && hit_thr)
      thr_sel_r <= reg_wdata_i[csof_pkg::THR_SEL_BIT];
  end

  // ****************************************************************
  // Output zero driver control register
  // ****************************************************************
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    // Status readback has no write path
    if (reg_wr_i && hit_ctrl)
      ctrl_nxt = reg_wdata_i & csof_pkg::CTL_WR_MASK;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ctrl_r <= csof_pkg::CTL_RST;
    else
      ctrl_r <= ctrl_nxt;
  end

  // ****************************************************************
  // Driver decode
  // ****************************************************************
  logic       fmt_cmos;
  logic [1:0] leg_cfg;
  logic [1:0] pol;
  logic       leg_a_en;
  logic       leg_b_en;
  logic       leg_a_inv;
  logic       leg_b_inv;

  assign fmt_cmos = ctrl_nxt[csof_pkg::CTL_FMT_BIT];
  assign leg_cfg  = ctrl_nxt[csof_pkg::CTL_LEG_HI:csof_pkg::CTL_LEG_LO];
  assign pol      = ctrl_nxt[csof_pkg::CTL_POL_HI:csof_pkg::CTL_POL_LO];

  always_comb
  begin
    leg_a_en = 1'b1;
    leg_b_en = 1'b1;
    if (fmt_cmos)
    begin
      case (leg_cfg)
        csof_pkg::LEG_NONE:
        begin
          leg_a_en = 1'b0;
          leg_b_en = 1'b0;
        end
        csof_pkg::LEG_A_ONLY:
        begin
          leg_a_en = 1'b1;
          leg_b_en = 1'b0;
        end
        csof_pkg::LEG_B_ONLY:
        begin
          leg_a_en = 1'b0;
          leg_b_en = 1'b1;
        end
        default:
        begin
          leg_a_en = 1'b1;
          leg_b_en = 1'b1;
        end
      endcase
    end
  end

  always_comb
  begin
    // Leg A follows the low polarity bit in both formats
    leg_a_inv = pol[0];
    if (fmt_cmos)
      leg_b_inv = pol[1] ^ pol[0];
    else
      leg_b_inv = ~pol[0];
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      output_zero_cmos_o      <= 1'b0;
      output_zero_leg_a_en_o  <= 1'b1;
      output_zero_leg_b_en_o  <= 1'b1;
      output_zero_leg_a_inv_o <= 1'b0;
      output_zero_leg_b_inv_o <= 1'b1;
    end
    else
    begin
      output_zero_cmos_o      <= fmt_cmos;
      output_zero_leg_a_en_o  <= leg_a_en;
      output_zero_leg_b_en_o  <= leg_b_en;
      output_zero_leg_a_inv_o <= leg_a_inv;
      output_zero_leg_b_inv_o <= leg_b_inv;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      freq_thr_sel_o <= csof_pkg::THR_SEL_RST;
    else
      freq_thr_sel_o <= (reg_wr_i && hit_thr)
                        ? reg_wdata_i[csof_pkg::THR_SEL_BIT] : thr_sel_r;
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [7:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = csof_pkg::RD_UNMAPPED;
    if (hit_status)
      rdata_nxt = {2'h0, status_sync};
    else if (hit_ctrl)
      rdata_nxt = ctrl_r;
    else if (hit_thr)
    begin
      rdata_nxt = 8'h00;
      rdata_nxt[csof_pkg::THR_SEL_BIT] = thr_sel_r;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
        reg_rdata_o <= rdata_nxt;
    end
  end

endmodule

// File: verif/csof_regs_props.sv
// Checker of register port and driver output relations
`timescale 1ns/1ps
module csof_regs_props #(
  parameter int unsigned ADDR_W = csof_pkg::ADDR_W
) (
  input wire logic              clk_sys_i,
  input wire logic              rst_b_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic              reg_wr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic              reg_rd_i,
  input wire logic [7:0]        reg_rdata_o,
  input wire logic              reg_rvalid_o,
  input wire logic              holdover_active_i,
  input wire logic              secondary_reference_sel_i,
  input wire logic              osc_above_thr_i,
  input wire logic              secondary_reference_above_thr_i,
  input wire logic              primary_reference_above_thr_i,
  input wire logic              pll_locked_i,
  input wire logic              freq_thr_sel_o,
  input wire logic              output_zero_cmos_o,
  input wire logic              output_zero_leg_a_en_o,
  input wire logic              output_zero_leg_b_en_o,
  input wire logic              output_zero_leg_a_inv_o,
  input wire logic              output_zero_leg_b_inv_o
);
  logic [5:0] st;
  logic [1:0] up_r;
  logic       wr_ctl;
  assign st = {holdover_active_i, secondary_reference_sel_i, osc_above_thr_i,
    secondary_reference_above_thr_i, primary_reference_above_thr_i,
    pll_locked_i};
  assign wr_ctl = reg_wr_i && reg_addr_i == csof_pkg::OFS_OUTPUT_ZERO_CTRL;
  // Edges since reset, saturating
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      up_r <= 2'h0;
    else if (up_r != 2'h3)
      up_r <= up_r + 2'h1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_steady;
    up_r == 2'h3 && st == $past(st) && st == $past(st, 2) && st == $past(st, 3);
  endsequence
  sequence s_rd_status;
    reg_rd_i && reg_addr_i == csof_pkg::OFS_STATUS_RB;
  endsequence
  a_rvalid_follows: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_rvalid_idle: assert property (!reg_rd_i |=> !reg_rvalid_o)
    else $error("spurious read valid");
  a_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  a_status_value: assert property (s_rd_status ##0 s_steady
    |=> reg_rdata_o == {2'h0, $past(st)})
    else $error("status readback wrong");
  a_format_bit: assert property (wr_ctl
    |=> output_zero_cmos_o == $past(reg_wdata_i[7]))
    else $error("format output wrong");
  a_leg_a_cmos: assert property (wr_ctl && reg_wdata_i[7]
    |=> output_zero_leg_a_en_o == $past(reg_wdata_i[5]))
    else $error("leg a enable wrong");
  a_lvds_legs_on: assert property (!output_zero_cmos_o
    |-> output_zero_leg_a_en_o && output_zero_leg_b_en_o)
    else $error("lvds leg disabled");
  a_pol_leg_a: assert property (wr_ctl
    |=> output_zero_leg_a_inv_o == $past(reg_wdata_i[3]))
    else $error("leg a polarity wrong");
  a_leg_b_cmos: assert property (wr_ctl && reg_wdata_i[7]
    |=> output_zero_leg_b_en_o == $past(reg_wdata_i[6]))
    else $error("leg b enable wrong");
  a_pol_leg_b: assert property (wr_ctl
    |=> output_zero_leg_b_inv_o == ($past(reg_wdata_i[7])
      ? $past(reg_wdata_i[4] ^ reg_wdata_i[3]) : !$past(reg_wdata_i[3])))
    else $error("leg b polarity wrong");
  a_thr_sel_copy: assert property (reg_wr_i
    && reg_addr_i == csof_pkg::OFS_THR_CFG
    |=> freq_thr_sel_o == $past(reg_wdata_i[6]))
    else $error("threshold select wrong");
endmodule

bind csof_regs csof_regs_props #(.ADDR_W(ADDR_W)) i_csof_regs_props (.*);

// File: verif/testbench.sv
// Self-checking testbench for the status and driver control registers
`timescale 1ns/1ps
module testbench;
  localparam int AW = csof_pkg::ADDR_W;
  logic          clk_sys_i = 1'b0;
  logic          rst_b_i = 1'b0;
  logic [AW-1:0] reg_addr_i = '0;
  logic          reg_wr_i = 1'b0;
  logic          reg_rd_i = 1'b0;
  logic [7:0]    reg_wdata_i = 8'h00;
  logic [5:0]    st = 6'h00;
  logic [7:0]    reg_rdata_o;
  logic [7:0]    d;
  logic          reg_rvalid_o;
  logic [4:0]    drv;
  logic          freq_thr_sel_o;
  int            err_count = 0;
  int            checks_done = 0;
  int            cyc = 0;
  csof_regs i_csof_regs (.clk_sys_i, .rst_b_i, .reg_addr_i, .reg_wr_i,
    .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
    .holdover_active_i(st[5]), .secondary_reference_sel_i(st[4]),
    .osc_above_thr_i(st[3]), .secondary_reference_above_thr_i(st[2]),
    .primary_reference_above_thr_i(st[1]), .pll_locked_i(st[0]),
    .freq_thr_sel_o, .output_zero_cmos_o(drv[4]),
    .output_zero_leg_a_en_o(drv[3]), .output_zero_leg_b_en_o(drv[2]),
    .output_zero_leg_a_inv_o(drv[1]), .output_zero_leg_b_inv_o(drv[0]));
  always #4 clk_sys_i = ~clk_sys_i;
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [AW-1:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b0;
    #1;
    chk({7'h0, reg_rvalid_o}, 8'h01);
    v = reg_rdata_o;
  endtask
  task automatic t_reset;
    chk({3'h0, drv}, 8'h0d);
    rd(csof_pkg::OFS_OUTPUT_ZERO_CTRL, d);
    chk(d, 8'h60);
    rd(csof_pkg::OFS_STATUS_RB, d);
    chk(d, 8'h00);
  endtask
  task automatic t_status;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_sys_i);
      st <= 6'h01 << i;
      repeat (3) @(posedge clk_sys_i);
      rd(csof_pkg::OFS_STATUS_RB, d);
      chk(d, 8'h01 << i);
    end
    wr(csof_pkg::OFS_STATUS_RB, 8'hff);
    rd(csof_pkg::OFS_STATUS_RB, d);
    chk(d, 8'h20);
  endtask
  task automatic t_ctrl;
    logic [4:0] v;
    logic [4:0] e;
    for (int i = 0; i < 32; i++)
    begin
      v = i[4:0];
      e[4] = v[4];
      e[3] = !v[4] | v[2];
      e[2] = !v[4] | v[3];
      e[1] = v[0];
      e[0] = v[4] ? v[1] ^ v[0] : !v[0];
      wr(csof_pkg::OFS_OUTPUT_ZERO_CTRL, {v, 3'h7});
      chk({3'h0, drv}, {3'h0, e});
      rd(csof_pkg::OFS_OUTPUT_ZERO_CTRL, d);
      chk(d, {v, 3'h0});
    end
  endtask
  task automatic t_misc;
    wr(csof_pkg::OFS_THR_CFG, 8'hff);
    chk({7'h0, freq_thr_sel_o}, 8'h01);
    rd(csof_pkg::OFS_THR_CFG, d);
    chk(d, 8'h40);
    rd(10'h3ff, d);
    chk(d, 8'h00);
  endtask
  task automatic t_midreset;
    @(posedge clk_sys_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    #1;
    chk({3'h0, drv}, 8'h0d);
    chk({7'h0, freq_thr_sel_o}, 8'h00);
    rd(csof_pkg::OFS_THR_CFG, d);
    chk(d, 8'h00);
    // Read and write in one cycle: read returns the old value
    @(posedge clk_sys_i);
    reg_addr_i  <= csof_pkg::OFS_OUTPUT_ZERO_CTRL;
    reg_wdata_i <= 8'h80;
    reg_wr_i    <= 1'b1;
    reg_rd_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b0;
    reg_rd_i    <= 1'b0;
    #1;
    chk(reg_rdata_o, 8'h60);
    chk({3'h0, drv}, 8'h10);
    rd(csof_pkg::OFS_OUTPUT_ZERO_CTRL, d);
    chk(d, 8'h80);
  endtask
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    #1;
    t_reset();
    t_status();
    t_ctrl();
    t_misc();
    t_midreset();
    end_of_test();
  end
endmodule
